//--- core/frame_buffer_pkg.sv
// Constants, state types and the CRC step shared by the packet framer.
// Assumes a 40 MHz core clock; all timing counts derive from it.
package frame_buffer_pkg;

	localparam int          CORE_CLK_MHZ   = 40;
	localparam int          BUF_WORDS      = 64;
	localparam int          WORD_W         = 16;
	localparam int          MAX_PAYLOAD    = 125;
	localparam int          PREAMBLE_BYTES = 4;
	localparam int          FCS_BYTES      = 2;
	localparam logic [7:0]  PREAMBLE_BYTE  = 8'h00;
	localparam logic [7:0]  SFD_BYTE       = 8'ha7;
	localparam logic [15:0] CRC_POLY_REV   = 16'h8408;
	localparam logic [15:0] CRC_INIT       = 16'h0000;
	localparam logic [15:0] CRC_RESIDUE    = 16'h0000;
	localparam int          LQI_WORD       = 63;
	localparam int          LQI_TIME_US    = 64;
	localparam int          LQI_CYC        = LQI_TIME_US * CORE_CLK_MHZ;
	localparam int          ED_TIME_US     = 128;
	localparam logic [7:0]  LEVEL_MAX      = 8'hff;

	typedef enum logic [2:0] {T_IDLE, T_PRE, T_SFD, T_LEN, T_DATA, T_FCS, T_DRAIN} tx_state_t;
	typedef enum logic [2:0] {R_HUNT, R_SFD, R_LEN, R_BODY, R_FIN} rx_state_t;

	// One byte of the reflected CRC-16, least significant bit first.
	function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		logic        fb;
		c = crc;
		for (int i = 0; i < 8; i++)
		begin
			fb = c[0] ^ b[i];
			c  = {1'b0, c[15:1]} ^ (fb ? CRC_POLY_REV : 16'h0000);
		end
		return c;
	endfunction

	// Mean of an energy sum over 2**sh samples, saturated to one byte.
	function automatic logic [7:0] avg8(input logic [31:0] acc, input int sh);
		logic [31:0] q;
		q = acc >> sh;
		return (q > 32'h0000_00ff) ? LEVEL_MAX : q[7:0];
	endfunction

endpackage

//--- core/byte_fifo.sv
// Small valid/ready FIFO used in the transmit byte path.
// Assumes DEPTH is a power of two; both sides run on one clock.
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
)(
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// Filling side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Draining side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wr_ptr_r;
	logic [AW:0]      rd_ptr_r;
	logic             do_wr;
	logic             do_rd;

	assign o_in_ready  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
	assign o_out_valid = wr_ptr_r != rd_ptr_r;
	assign o_out_data  = mem_r[rd_ptr_r[AW-1:0]];
	assign do_wr       = i_in_valid && o_in_ready;
	assign do_rd       = o_out_valid && i_out_ready;

	always_ff @(posedge i_clk)
	begin
		if (do_wr)
			mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_r + (AW+1)'(do_wr);
			rd_ptr_r <= rd_ptr_r + (AW+1)'(do_rd);
		end
	end

endmodule

//--- core/packet_mode_frame_buffer.sv
// Packet-mode framer: transmit and receive packet RAMs, framing, CRC, LQI and ED.
// Assumes host ports and baseband energy are on the core clock; link bytes
// move on a free-running link clock, one byte per link valid pulse.
`timescale 1ns/1ps
module packet_mode_frame_buffer
	import frame_buffer_pkg::*;
#(
	parameter int ED_CYCLES = ED_TIME_US * CORE_CLK_MHZ
)(
	// Clocks and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_link_clk,
	// Transmit RAM and start
	input  wire logic        i_tx_wr_en,
	input  wire logic [5:0]  i_tx_wr_addr,
	input  wire logic [15:0] i_tx_wr_data,
	input  wire logic [6:0]  i_tx_len,
	input  wire logic        i_tx_start,
	// Receive RAM and result
	input  wire logic [5:0]  i_rx_rd_addr,
	output logic [15:0]      o_rx_rd_data,
	output logic [6:0]       o_rx_len,
	output logic             o_rx_crc_ok,
	output logic [7:0]       o_rx_lqi,
	// Status and interrupt
	input  wire logic        i_irq_clr,
	output logic             o_irq,
	output logic             o_tx_busy,
	output logic             o_tx_done,
	output logic             o_rx_done,
	// Energy detect
	input  wire logic        i_ed_start,
	input  wire logic [7:0]  i_bb_energy,
	output logic [7:0]       o_ed_level,
	output logic             o_ed_done,
	// Link side, link clock
	output logic [7:0]       o_link_tx_data,
	output logic             o_link_tx_valid,
	input  wire logic        i_link_tx_ready,
	input  wire logic        i_link_rx_valid,
	input  wire logic [7:0]  i_link_rx_data
);
	localparam int LQI_SH = $clog2(LQI_CYC);
	localparam int ED_SH  = $clog2(ED_CYCLES);

	logic [WORD_W-1:0] tx_ram [BUF_WORDS];
	logic [WORD_W-1:0] rx_ram [BUF_WORDS];

	tx_state_t   tx_state_r;
	logic [6:0]  tx_cnt_r;
	logic [6:0]  tx_len_r;
	logic [15:0] tx_crc_r;
	logic [7:0]  tx_hold_r;
	logic        tx_req_r;
	logic        tx_busy_r;
	logic        tx_ack_s1;
	logic        tx_ack_s2;
	rx_state_t   rx_state_r;
	logic [6:0]  rx_cnt_r;
	logic [6:0]  rx_len_r;
	logic [15:0] rx_crc_r;
	logic        rx_tgl_s1;
	logic        rx_tgl_s2;
	logic        rx_tgl_s3;
	logic [11:0] lqi_cnt_r;
	logic [31:0] lqi_acc_r;
	logic [7:0]  lqi_r;
	int          ed_cnt_r;
	logic [31:0] ed_acc_r;
	logic [15:0] rd_data_r;
	logic [6:0]  rx_len_out_r;
	logic        crc_ok_r;
	logic [7:0]  lqi_out_r;
	logic        irq_r;
	logic        tx_done_r;
	logic        rx_done_r;
	logic [7:0]  ed_level_r;
	logic        ed_done_r;
	// Link-domain state.
	logic        lrst_s1;
	logic        lrst_s2;
	logic        ltx_req_s1;
	logic        ltx_req_s2;
	logic        ltx_seen_r;
	logic        ltx_ack_r;
	logic [7:0]  ltx_data_r;
	logic        ltx_valid_r;
	logic [7:0]  lrx_hold_r;
	logic        lrx_tgl_r;

	// Transmit byte selection.
	logic [15:0] tx_word;
	logic [7:0]  tx_pay;
	logic [7:0]  tx_byte;
	logic        tx_emit;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [7:0]  fifo_out_data;
	logic        cross_free;
	logic        tx_fire;
	logic        tx_go;
	logic        tx_end;

	assign tx_word  = tx_ram[tx_cnt_r[6:1]];
	assign tx_pay   = tx_cnt_r[0] ? tx_word[15:8] : tx_word[7:0];
	assign tx_byte  = (tx_state_r == T_PRE)  ? PREAMBLE_BYTE :
	                  (tx_state_r == T_SFD)  ? SFD_BYTE :
	                  (tx_state_r == T_LEN)  ? {1'b0, tx_len_r + 7'(FCS_BYTES)} :
	                  (tx_state_r == T_DATA) ? tx_pay :
	                  (tx_cnt_r[0] ? tx_crc_r[15:8] : tx_crc_r[7:0]);
	assign tx_emit  = (tx_state_r != T_IDLE) && (tx_state_r != T_DRAIN);
	assign tx_fire  = tx_emit && fifo_in_ready;
	assign cross_free = tx_req_r == tx_ack_s2;
	assign tx_go    = (tx_state_r == T_IDLE) && i_tx_start && (i_tx_len <= 7'(MAX_PAYLOAD));
	assign tx_end   = (tx_state_r == T_DRAIN) && !fifo_out_valid && cross_free;

	always_ff @(posedge i_core_clk)
	begin
		if (i_tx_wr_en)
			tx_ram[i_tx_wr_addr] <= i_tx_wr_data;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			tx_state_r <= T_IDLE;
			tx_busy_r  <= 1'b0;
			tx_cnt_r   <= '0;
			tx_len_r   <= '0;
			tx_crc_r   <= CRC_INIT;
		end
		else if (tx_go)
		begin
			tx_state_r <= T_PRE;
			tx_busy_r  <= 1'b1;
			tx_cnt_r   <= '0;
			tx_len_r   <= i_tx_len;
			tx_crc_r   <= CRC_INIT;
		end
		else if (tx_end)
		begin
			tx_state_r <= T_IDLE;
			tx_busy_r  <= 1'b0;
		end
		else if (tx_fire)
		begin
			tx_cnt_r <= tx_cnt_r + 7'd1;
			unique case (tx_state_r)
				T_PRE:
					if (tx_cnt_r == 7'(PREAMBLE_BYTES - 1))
					begin
						tx_state_r <= T_SFD;
						tx_cnt_r   <= '0;
					end
				T_SFD:
					tx_state_r <= T_LEN;
				T_LEN:
				begin
					tx_state_r <= (tx_len_r == 7'd0) ? T_FCS : T_DATA;
					tx_cnt_r   <= '0;
				end
				T_DATA:
				begin
					tx_crc_r <= crc16_byte(tx_crc_r, tx_pay);
					if (tx_cnt_r == tx_len_r - 7'd1)
					begin
						tx_state_r <= T_FCS;
						tx_cnt_r   <= '0;
					end
				end
				T_FCS:
					if (tx_cnt_r[0])
						tx_state_r <= T_DRAIN;
				T_IDLE, T_DRAIN:
					tx_state_r <= tx_state_r;
			endcase
		end
	end

	byte_fifo #(
		.WIDTH(8),
		.DEPTH(2)
	) u_tx_fifo (
		.i_clk       (i_core_clk),
		.i_rst       (i_sys_rst),
		.i_in_valid  (tx_emit),
		.i_in_data   (tx_byte),
		.o_in_ready  (fifo_in_ready),
		.o_out_valid (fifo_out_valid),
		.o_out_data  (fifo_out_data),
		.i_out_ready (cross_free)
	);

	// Byte handed to the link domain by a toggle handshake; hold stays put until acked.
	always_ff @(posedge i_core_clk)
	begin
		tx_ack_s1 <= ltx_ack_r;
		tx_ack_s2 <= tx_ack_s1;
		if (i_sys_rst)
		begin
			tx_req_r  <= 1'b0;
			tx_hold_r <= '0;
		end
		else if (fifo_out_valid && cross_free)
		begin
			tx_req_r  <= ~tx_req_r;
			tx_hold_r <= fifo_out_data;
		end
	end

	always_ff @(posedge i_link_clk)
	begin
		lrst_s1    <= i_sys_rst;
		lrst_s2    <= lrst_s1;
		ltx_req_s1 <= tx_req_r;
		ltx_req_s2 <= ltx_req_s1;
	end

	always_ff @(posedge i_link_clk)
	begin
		if (lrst_s2)
		begin
			ltx_seen_r  <= 1'b0;
			ltx_ack_r   <= 1'b0;
			ltx_data_r  <= '0;
			ltx_valid_r <= 1'b0;
			lrx_hold_r  <= '0;
			lrx_tgl_r   <= 1'b0;
		end
		else
		begin
			if (!ltx_valid_r && (ltx_req_s2 != ltx_seen_r))
			begin
				ltx_data_r  <= tx_hold_r;
				ltx_valid_r <= 1'b1;
				ltx_seen_r  <= ltx_req_s2;
			end
			else if (ltx_valid_r && i_link_tx_ready)
			begin
				ltx_valid_r <= 1'b0;
				ltx_ack_r   <= ~ltx_ack_r;
			end
			if (i_link_rx_valid)
			begin
				lrx_hold_r <= i_link_rx_data;
				lrx_tgl_r  <= ~lrx_tgl_r;
			end
		end
	end

	// Receive side.
	logic       rx_stb;
	logic [7:0] rx_byte;
	logic       lqi_go;
	logic       rx_wr;
	logic       rx_fin;

	assign rx_stb  = rx_tgl_s2 ^ rx_tgl_s3;
	assign rx_byte = lrx_hold_r;
	assign lqi_go  = rx_stb && (rx_state_r == R_HUNT) && (rx_byte == PREAMBLE_BYTE)
	                 && (rx_cnt_r == 7'(PREAMBLE_BYTES - 1));
	assign rx_wr   = rx_stb && (rx_state_r == R_BODY);
	assign rx_fin  = (rx_state_r == R_FIN) && (lqi_cnt_r == '0);

	always_ff @(posedge i_core_clk)
	begin
		rx_tgl_s1 <= lrx_tgl_r;
		rx_tgl_s2 <= rx_tgl_s1;
		rx_tgl_s3 <= rx_tgl_s2;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			rx_state_r <= R_HUNT;
			rx_cnt_r   <= '0;
			rx_len_r   <= '0;
			rx_crc_r   <= CRC_INIT;
		end
		else if (rx_fin)
		begin
			rx_state_r <= R_HUNT;
			rx_cnt_r   <= '0;
		end
		else if (rx_stb)
		begin
			unique case (rx_state_r)
				R_HUNT:
					if (rx_byte != PREAMBLE_BYTE)
						rx_cnt_r <= '0;
					else if (lqi_go)
						rx_state_r <= R_SFD;
					else
						rx_cnt_r <= rx_cnt_r + 7'd1;
				R_SFD:
					if (rx_byte == SFD_BYTE)
						rx_state_r <= R_LEN;
					else if (rx_byte != PREAMBLE_BYTE)
					begin
						rx_state_r <= R_HUNT;
						rx_cnt_r   <= '0;
					end
				R_LEN:
				begin
					rx_len_r   <= rx_byte[6:0];
					rx_cnt_r   <= '0;
					rx_crc_r   <= CRC_INIT;
					rx_state_r <= (rx_byte[6:0] < 7'(FCS_BYTES)) ? R_HUNT : R_BODY;
				end
				R_BODY:
				begin
					rx_crc_r <= crc16_byte(rx_crc_r, rx_byte);
					rx_cnt_r <= rx_cnt_r + 7'd1;
					if (rx_cnt_r == rx_len_r - 7'd1)
						rx_state_r <= R_FIN;
				end
				R_FIN:
					rx_state_r <= R_FIN;
			endcase
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			lqi_cnt_r <= '0;
			lqi_acc_r <= '0;
			lqi_r     <= '0;
		end
		else if (lqi_go)
		begin
			lqi_cnt_r <= 12'(LQI_CYC);
			lqi_acc_r <= '0;
		end
		else if (lqi_cnt_r != '0)
		begin
			lqi_cnt_r <= lqi_cnt_r - 12'd1;
			lqi_acc_r <= lqi_acc_r + 32'(i_bb_energy);
			if (lqi_cnt_r == 12'd1)
				lqi_r <= avg8(lqi_acc_r + 32'(i_bb_energy), LQI_SH);
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (rx_wr && rx_cnt_r[0])
			rx_ram[rx_cnt_r[6:1]][15:8] <= rx_byte;
		else if (rx_wr)
			rx_ram[rx_cnt_r[6:1]][7:0] <= rx_byte;
		else if (rx_fin)
			rx_ram[LQI_WORD][15:8] <= lqi_r;
		rd_data_r <= rx_ram[i_rx_rd_addr];
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			ed_cnt_r   <= 0;
			ed_acc_r   <= '0;
			ed_level_r <= '0;
			ed_done_r  <= 1'b0;
		end
		else if (i_ed_start && (ed_cnt_r == 0))
		begin
			ed_cnt_r  <= ED_CYCLES;
			ed_acc_r  <= '0;
			ed_done_r <= 1'b0;
		end
		else if (ed_cnt_r != 0)
		begin
			ed_cnt_r <= ed_cnt_r - 1;
			ed_acc_r <= ed_acc_r + 32'(i_bb_energy);
			if (ed_cnt_r == 1)
			begin
				ed_level_r <= avg8(ed_acc_r + 32'(i_bb_energy), ED_SH);
				ed_done_r  <= 1'b1;
			end
		end
	end

	// Status flags: an event in the clear cycle wins.
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			irq_r        <= 1'b0;
			tx_done_r    <= 1'b0;
			rx_done_r    <= 1'b0;
			rx_len_out_r <= '0;
			crc_ok_r     <= 1'b0;
			lqi_out_r    <= '0;
		end
		else
		begin
			tx_done_r <= (tx_done_r && !i_irq_clr) || tx_end;
			rx_done_r <= (rx_done_r && !i_irq_clr) || rx_fin;
			irq_r     <= (irq_r && !i_irq_clr) || tx_end || rx_fin;
			if (rx_fin)
			begin
				rx_len_out_r <= rx_len_r;
				crc_ok_r     <= rx_crc_r == CRC_RESIDUE;
				lqi_out_r    <= lqi_r;
			end
		end
	end

	assign o_rx_rd_data    = rd_data_r;
	assign o_rx_len        = rx_len_out_r;
	assign o_rx_crc_ok     = crc_ok_r;
	assign o_rx_lqi        = lqi_out_r;
	assign o_irq           = irq_r;
	assign o_tx_busy       = tx_busy_r;
	assign o_tx_done       = tx_done_r;
	assign o_rx_done       = rx_done_r;
	assign o_ed_level      = ed_level_r;
	assign o_ed_done       = ed_done_r;
	assign o_link_tx_data  = ltx_data_r;
	assign o_link_tx_valid = ltx_valid_r;

endmodule

//--- test/packet_mode_frame_buffer_monitor.sv
// Port-level checker for the packet framer.
// Assumes it is bound into packet_mode_frame_buffer.
`timescale 1ns/1ps
module packet_mode_frame_buffer_monitor (
	input wire logic       i_core_clk,
	input wire logic       i_sys_rst,
	input wire logic       i_link_clk,
	input wire logic [6:0] i_tx_len,
	input wire logic       i_tx_start,
	input wire logic       i_irq_clr,
	input wire logic       i_ed_start,
	input wire logic       o_irq,
	input wire logic       o_tx_busy,
	input wire logic       o_tx_done,
	input wire logic       o_rx_done,
	input wire logic [6:0] o_rx_len,
	input wire logic       o_ed_done,
	input wire logic [7:0] o_link_tx_data,
	input wire logic       o_link_tx_valid,
	input wire logic       i_link_tx_ready
);
	a_start_taken: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_tx_start && !o_tx_busy && i_tx_len <= 7'h7d |=> o_tx_busy)
		else $error("start not taken");
	a_long_refused: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_tx_start && !o_tx_busy && i_tx_len > 7'h7d |=> !o_tx_busy)
		else $error("overlong start taken");
	a_busy_ends_done: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		$fell(o_tx_busy) |-> o_tx_done && o_irq)
		else $error("busy fell without done");
	a_irq_has_cause: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		$rose(o_irq) |-> $rose(o_tx_done) || $rose(o_rx_done))
		else $error("irq without cause");
	a_rx_done_irq: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		$rose(o_rx_done) |-> o_irq)
		else $error("rx done without irq");
	a_clear_done: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		i_irq_clr && !o_tx_busy |=> !o_tx_done)
		else $error("tx done not cleared");
	a_rx_len_min: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		$rose(o_rx_done) |-> o_rx_len >= 7'h02)
		else $error("short frame reported");
	a_ed_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		$fell(o_ed_done) |-> $past(i_ed_start))
		else $error("ed done dropped");
	a_link_hold: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
		o_link_tx_valid && !i_link_tx_ready |=> o_link_tx_valid && $stable(o_link_tx_data))
		else $error("link byte not held");
	c_tx_done: cover property (@(posedge i_core_clk) $rose(o_tx_done));
	c_rx_done: cover property (@(posedge i_core_clk) $rose(o_rx_done));
	c_ed_done: cover property (@(posedge i_core_clk) $rose(o_ed_done));
	c_stall: cover property (@(posedge i_link_clk) o_link_tx_valid && !i_link_tx_ready);
endmodule

//--- test/link_partner.sv
// Far end of the byte link: takes framed bytes and sends frames back.
// Assumes a free-running link clock from the bench.
`timescale 1ns/1ps
module link_partner (
	input  wire logic       i_link_clk,
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_valid,
	output logic            o_tx_ready,
	output logic            o_rx_valid,
	output logic [7:0]      o_rx_data
);
	logic       stall;
	logic       ph_r;
	logic [7:0] got[$];
	initial
	begin
		stall = 1'b0;
		ph_r = 1'b0;
		o_rx_valid = 1'b0;
		o_rx_data = 8'h00;
	end
	// When stalling, ready is offered only every other cycle.
	assign o_tx_ready = !stall || ph_r;
	always @(posedge i_link_clk)
	begin
		ph_r <= ~ph_r;
		if (i_tx_valid && o_tx_ready)
			got.push_back(i_tx_data);
	end
	task automatic send(input logic [7:0] b);
		@(posedge i_link_clk);
		o_rx_valid <= 1'b1;
		o_rx_data <= b;
		@(posedge i_link_clk);
		o_rx_valid <= 1'b0;
		o_rx_data <= ~b;
		repeat (3) @(posedge i_link_clk);
	endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the packet framer with a link partner.
// Assumes a 40 MHz core clock and a 32 ns link clock.
`timescale 1ns/1ps
module testbench;
	import frame_buffer_pkg::*;
	typedef logic [7:0] bytes_t[$];
	logic        i_core_clk = 1'b0, i_link_clk = 1'b0, i_sys_rst = 1'b1;
	logic        i_tx_wr_en, i_tx_start, i_irq_clr, i_ed_start;
	logic [5:0]  i_tx_wr_addr, i_rx_rd_addr;
	logic [15:0] i_tx_wr_data, o_rx_rd_data;
	logic [6:0]  i_tx_len, o_rx_len;
	logic [7:0]  i_bb_energy, o_rx_lqi, o_ed_level, link_tx_data, link_rx_data;
	logic        o_rx_crc_ok, o_irq, o_tx_busy, o_tx_done, o_rx_done, o_ed_done;
	logic        link_tx_valid, link_tx_ready, link_rx_valid;
	int          errors = 0, num_checks = 0;

	always #12.5 i_core_clk = ~i_core_clk;
	always #16 i_link_clk = ~i_link_clk;

	packet_mode_frame_buffer #(.ED_CYCLES(16)) packet_mode_frame_buffer_inst (
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk),
		.i_tx_wr_en(i_tx_wr_en), .i_tx_wr_addr(i_tx_wr_addr), .i_tx_wr_data(i_tx_wr_data),
		.i_tx_len(i_tx_len), .i_tx_start(i_tx_start), .i_rx_rd_addr(i_rx_rd_addr),
		.o_rx_rd_data(o_rx_rd_data), .o_rx_len(o_rx_len), .o_rx_crc_ok(o_rx_crc_ok),
		.o_rx_lqi(o_rx_lqi), .i_irq_clr(i_irq_clr), .o_irq(o_irq), .o_tx_busy(o_tx_busy),
		.o_tx_done(o_tx_done), .o_rx_done(o_rx_done), .i_ed_start(i_ed_start),
		.i_bb_energy(i_bb_energy), .o_ed_level(o_ed_level), .o_ed_done(o_ed_done),
		.o_link_tx_data(link_tx_data), .o_link_tx_valid(link_tx_valid),
		.i_link_tx_ready(link_tx_ready), .i_link_rx_valid(link_rx_valid),
		.i_link_rx_data(link_rx_data));

	link_partner link_partner_inst (.i_link_clk(i_link_clk), .i_tx_data(link_tx_data),
		.i_tx_valid(link_tx_valid), .o_tx_ready(link_tx_ready),
		.o_rx_valid(link_rx_valid), .o_rx_data(link_rx_data));

	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic bytes_t mkframe(input bytes_t pl);
		bytes_t      f;
		logic [15:0] c;
		c = CRC_INIT;
		foreach (pl[i])
			for (int b = 0; b < 8; b++)
				c = {1'b0, c[15:1]} ^ ((c[0] ^ pl[i][b]) ? CRC_POLY_REV : 16'h0000);
		for (int i = 0; i < PREAMBLE_BYTES; i++)
			f.push_back(PREAMBLE_BYTE);
		f.push_back(SFD_BYTE);
		f.push_back(8'(pl.size() + FCS_BYTES));
		foreach (pl[i])
			f.push_back(pl[i]);
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		return f;
	endfunction

	task automatic clear_irq;
		i_irq_clr = 1'b1;
		@(negedge i_core_clk);
		i_irq_clr = 1'b0;
		@(negedge i_core_clk);
		chk("irq_clear", 16'({o_irq, o_tx_done, o_rx_done}), 16'h0000);
	endtask

	task automatic t_refuse;
		i_tx_len = 7'h7e;
		i_tx_start = 1'b1;
		@(negedge i_core_clk);
		i_tx_start = 1'b0;
		@(negedge i_core_clk);
		chk("refuse", 16'({o_tx_busy, o_tx_done}), 16'h0000);
	endtask

	task automatic t_tx(input int len, input logic stl);
		bytes_t pl;
		bytes_t f;
		for (int n = 0; n < len; n++)
			pl.push_back(8'(n * 7 + 1));
		for (int w = 0; 2 * w < len; w++)
		begin
			i_tx_wr_en = 1'b1;
			i_tx_wr_addr = 6'(w);
			i_tx_wr_data = {8'(14 * w + 8), pl[2 * w]};
			@(negedge i_core_clk);
		end
		i_tx_wr_en = 1'b0;
		link_partner_inst.stall = stl;
		link_partner_inst.got.delete();
		i_tx_len = 7'(len);
		i_tx_start = 1'b1;
		@(negedge i_core_clk);
		chk("tx_busy", 16'(o_tx_busy), 16'h0001);
		// A second start while busy must be ignored.
		i_tx_len = 7'h01;
		@(negedge i_core_clk);
		i_tx_start = 1'b0;
		for (int i = 0; i < 40000 && o_tx_done !== 1'b1; i++)
			@(negedge i_core_clk);
		chk("tx_irq", 16'({o_irq, o_tx_busy, o_tx_done}), 16'h0005);
		repeat (40) @(negedge i_core_clk);
		f = mkframe(pl);
		chk("tx_count", 16'(link_partner_inst.got.size()), 16'(f.size()));
		foreach (f[i])
			chk("tx_byte", 16'(link_partner_inst.got[i]), 16'(f[i]));
		clear_irq();
	endtask

	task automatic t_rx(input int len, input logic bad);
		bytes_t pl;
		bytes_t f;
		for (int n = 0; n < len; n++)
			pl.push_back(8'(n + 8'h30));
		f = mkframe(pl);
		// Energy 0x40 over the 2560-cycle window, scaled by 1/4096, gives 0x28.
		i_bb_energy = 8'h40;
		if (bad)
		begin
			// A broken preamble and a frame too short for its check sequence are dropped.
			link_partner_inst.send(PREAMBLE_BYTE);
			link_partner_inst.send(8'h55);
			for (int i = 0; i < 5; i++)
				link_partner_inst.send(f[i]);
			link_partner_inst.send(8'h01);
			f[f.size() - 1] = ~f[f.size() - 1];
		end
		foreach (f[i])
			link_partner_inst.send(f[i]);
		for (int i = 0; i < 8000 && o_rx_done !== 1'b1; i++)
			@(negedge i_core_clk);
		chk("rx_irq", 16'({o_irq, o_rx_done}), 16'h0003);
		chk("rx_len", 16'(o_rx_len), 16'(len + 2));
		chk("rx_crc", 16'(o_rx_crc_ok), 16'(!bad));
		chk("rx_lqi", 16'(o_rx_lqi), 16'h0028);
		for (int k = 6; k < f.size(); k++)
		begin
			i_rx_rd_addr = 6'((k - 6) >> 1);
			@(negedge i_core_clk);
			chk("rx_ram", 16'(k[0] ? o_rx_rd_data[15:8] : o_rx_rd_data[7:0]), 16'(f[k]));
		end
		i_rx_rd_addr = 6'h3f;
		@(negedge i_core_clk);
		chk("lqi_word", 16'(o_rx_rd_data[15:8]), 16'h0028);
		i_bb_energy = 8'h00;
		clear_irq();
	endtask

	task automatic t_ed(input logic [7:0] e);
		i_bb_energy = e;
		i_ed_start = 1'b1;
		@(negedge i_core_clk);
		i_ed_start = 1'b0;
		for (int i = 0; i < 200 && o_ed_done !== 1'b1; i++)
			@(negedge i_core_clk);
		chk("ed_done", 16'(o_ed_done), 16'h0001);
		chk("ed_level", 16'(o_ed_level), 16'(e));
		i_bb_energy = 8'h00;
	endtask

	task automatic give_verdict;
		$display("errors=%0d num_checks=%0d", errors, num_checks);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		{i_tx_wr_en, i_tx_start, i_irq_clr, i_ed_start} = 4'h0;
		{i_tx_wr_addr, i_rx_rd_addr, i_tx_wr_data} = 28'h0000000;
		i_tx_len = 7'h00;
		i_bb_energy = 8'h00;
		repeat (8) @(negedge i_core_clk);
		i_sys_rst = 1'b0;
		repeat (8) @(negedge i_core_clk);
		t_refuse();
		t_tx(3, 1'b0);
		t_tx(0, 1'b0);
		t_tx(125, 1'b1);
		t_rx(4, 1'b0);
		t_rx(125, 1'b0);
		t_rx(4, 1'b1);
		t_ed(8'h40);
		t_ed(8'hff);
		give_verdict();
	end

	initial
	begin
		#2000000;
		errors++;
		give_verdict();
	end
endmodule

bind packet_mode_frame_buffer packet_mode_frame_buffer_monitor
	packet_mode_frame_buffer_monitor_inst (
	.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk),
	.i_tx_len(i_tx_len), .i_tx_start(i_tx_start), .i_irq_clr(i_irq_clr),
	.i_ed_start(i_ed_start), .o_irq(o_irq), .o_tx_busy(o_tx_busy), .o_tx_done(o_tx_done),
	.o_rx_done(o_rx_done), .o_rx_len(o_rx_len), .o_ed_done(o_ed_done),
	.o_link_tx_data(o_link_tx_data), .o_link_tx_valid(o_link_tx_valid),
	.i_link_tx_ready(i_link_tx_ready));
